// *** ped_top.sv ***
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module ped_top
    import ped_pkg::*;
(
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic rst, // Async reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic enh_en_n, // Enhancement enable, active low
    input wire logic main_div_clk, // Main divider output
    input wire logic ref_div_clk, // Reference divider output
    input wire logic modulus_select, // Internal prescaler modulus select
    input wire logic presc_raw, // Raw prescaler output
    output logic pump_up_n, // Up pulse, active low
    output logic pump_down_n, // Down pulse, active low
    output logic integ_node, // Integration node drive
    output logic lock_detect_o, // Lock detect pin level when driven
    output logic lock_detect_oe, // Lock detect pin pulls low
    output logic main_div_out, // Main divided clock out
    output logic ref_div_out, // Reference divided clock out
    output logic diag_out, // Diagnostic output pin
    output logic cnt_load, // Continuous counter load request
    output logic pwr_down // Power-down to analog and counters
);

    // Register state
    logic [PED_ENH_W-1:0] enh_q;
    logic [PED_EV_W-1:0] event_q;
    logic [PED_EV_W-1:0] event_d;
    typedef enum logic [1:0] {
        PED_PFD_IDLE = 2'b00,
        PED_PFD_UP = 2'b01,
        PED_PFD_DOWN = 2'b10
    } ped_pfd_state_t;
    ped_pfd_state_t pfd_state_q;
    ped_pfd_state_t pfd_state_d;
    ped_pfd_t pfd_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic pump_up_n_q;
    logic pump_down_n_q;
    logic integ_node_q;
    logic lock_oe_q;
    logic lock_o_q;
    logic main_div_out_q;
    logic ref_div_out_q;
    logic diag_out_q;
    logic cnt_load_q;
    logic pwr_down_q;

    // APB decode
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire hit_enh = (paddr == PED_ADDR_ENH);
    wire hit_status = (paddr == PED_ADDR_STATUS);
    wire hit_event = (paddr == PED_ADDR_EVENT);
    wire addr_ok = hit_enh | hit_status | hit_event;
    wire wr_enh = access_ph & pready_q & pwrite & hit_enh & pstrb[0];
    wire wr_event = access_ph & pready_q & pwrite & hit_event & pstrb[0];

    // Enhancement decode; register holds only the used bits
    wire enh_active = ~enh_en_n;
    ped_ctrl_t ctrl;
    assign ctrl.pwr_down = enh_active & enh_q[PED_ENH_PWRDN_BIT];
    assign ctrl.cnt_load = enh_active & enh_q[PED_ENH_CNTLD_BIT];
    assign ctrl.modsel_out = enh_active & enh_q[PED_ENH_MODSEL_BIT];
    assign ctrl.presc_out = enh_active & enh_q[PED_ENH_PRESC_BIT];
    assign ctrl.div_off = enh_active & enh_q[PED_ENH_DIVOFF_BIT];

    // Diagnostic steering: modulus select has priority
    wire ped_diag_sel_t diag_sel = ctrl.modsel_out ? PED_DIAG_MODSEL :
                                   ctrl.presc_out ? PED_DIAG_PRESC : PED_DIAG_LOW;
    logic diag_d;
    always_comb begin
        case (diag_sel)
            PED_DIAG_MODSEL: diag_d = modulus_select;
            PED_DIAG_PRESC: diag_d = presc_raw;
            PED_DIAG_LOW: diag_d = 1'b0;
            default: diag_d = 1'b0;
        endcase
    end

    // Edge detection of divider outputs
    logic [PED_EDGE_N-1:0] rise;
    logic [PED_EDGE_N-1:0] div_lvl;
    assign div_lvl[PED_LANE_MAIN] = main_div_clk;
    assign div_lvl[PED_LANE_REF] = ref_div_clk;

    ped_rise_det u_rise (
        .clk_sys(clk_sys),
        .rst(rst),
        .sig_in(div_lvl),
        .rise_q(rise)
    );

    wire main_rise = rise[PED_LANE_MAIN] & ~ctrl.pwr_down;
    wire ref_rise = rise[PED_LANE_REF] & ~ctrl.pwr_down;

    // Tri-state detector: the leading edge opens a pulse, the lagging edge closes it
    always_comb begin
        pfd_state_d = pfd_state_q;
        case (pfd_state_q)
            PED_PFD_IDLE: begin
                if (ref_rise && !main_rise) begin
                    pfd_state_d = PED_PFD_UP;
                end else if (main_rise && !ref_rise) begin
                    pfd_state_d = PED_PFD_DOWN;
                end
            end
            PED_PFD_UP: begin
                if (main_rise) begin
                    pfd_state_d = PED_PFD_IDLE;
                end
            end
            PED_PFD_DOWN: begin
                if (ref_rise) begin
                    pfd_state_d = PED_PFD_IDLE;
                end
            end
            default: begin
                pfd_state_d = PED_PFD_IDLE;
            end
        endcase
        // Power-down drops a half-finished pulse rather than let it stretch
        if (ctrl.pwr_down) begin
            pfd_state_d = PED_PFD_IDLE;
        end
    end
    assign pfd_d.up = (pfd_state_d == PED_PFD_UP);
    assign pfd_d.down = (pfd_state_d == PED_PFD_DOWN);

    // Sticky events: a new pulse beats a clear in the same cycle
    logic [PED_EV_W-1:0] ev_set;
    always_comb begin
        ev_set = '0;
        ev_set[PED_EV_UP_BIT] = pfd_d.up;
        ev_set[PED_EV_DOWN_BIT] = pfd_d.down;
    end
    wire [PED_EV_W-1:0] ev_clr = wr_event ? pwdata[PED_EV_W-1:0] : {PED_EV_W{1'b0}};
    assign event_d = ev_set | (event_q & ~ev_clr);

    // Status word, one field per bit position
    logic [31:0] status_word;
    always_comb begin
        status_word = PED_ZERO_WORD;
        status_word[PED_ST_LOCK_BIT] = ~lock_oe_q;
        status_word[PED_ST_UP_BIT] = ~pump_up_n_q;
        status_word[PED_ST_DOWN_BIT] = ~pump_down_n_q;
        status_word[PED_ST_PWRDN_BIT] = pwr_down_q;
        status_word[PED_ST_CNTLD_BIT] = cnt_load_q;
        status_word[PED_ST_DIAG_BIT] = diag_out_q;
        status_word[PED_ST_ENHACT_BIT] = enh_active;
    end

    wire [31:0] rd_mux = hit_status ? status_word :
                         hit_event ? {30'h0000_0000, event_q} : PED_ZERO_WORD;

    // APB slave: one wait-free access, data registered in setup
    wire pready_d = setup_ph;
    wire pslverr_d = setup_ph & ~addr_ok;
    wire [31:0] prdata_d = (setup_ph & ~pwrite) ? rd_mux : PED_ZERO_WORD;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= pslverr_d;
        end
    end

    // Read data stays zero outside a read access, so nothing stale reaches the bus
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_q <= PED_ZERO_WORD;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // Enhancement register keeps taking writes during power-down
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enh_q <= PED_ENH_RESET;
        end else if (wr_enh) begin
            enh_q <= pwdata[PED_ENH_W-1:0] & PED_ENH_USED_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pfd_state_q <= PED_PFD_IDLE;
        end else begin
            pfd_state_q <= pfd_state_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            event_q <= '0;
        end else begin
            event_q <= event_d;
        end
    end

    // Pump, node and lock outputs; idle high means no correction
    wire up_n_d = ~pfd_d.up;
    wire down_n_d = ~pfd_d.down;
    wire integ_node_d = ~(up_n_d & down_n_d);
    // Comparator inverts the node, so the pin is pulled low exactly while a pump is active
    wire lock_oe_d = ~(up_n_d & down_n_d);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pump_up_n_q <= 1'b1;
        end else begin
            pump_up_n_q <= up_n_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pump_down_n_q <= 1'b1;
        end else begin
            pump_down_n_q <= down_n_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            integ_node_q <= 1'b0;
        end else begin
            integ_node_q <= integ_node_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_oe_q <= 1'b0;
        end else begin
            lock_oe_q <= lock_oe_d;
        end
    end

    // Open drain: the driven level is always low, only the enable moves
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_o_q <= 1'b0;
        end else begin
            lock_o_q <= 1'b0;
        end
    end

    // Enhancement-driven outputs; power-down silences the divided clocks too
    wire div_gate = ~ctrl.div_off & ~ctrl.pwr_down;
    wire main_div_out_d = main_div_clk & div_gate;
    wire ref_div_out_d = ref_div_clk & div_gate;
    wire diag_out_d = diag_d & ~ctrl.pwr_down;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            main_div_out_q <= 1'b0;
        end else begin
            main_div_out_q <= main_div_out_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ref_div_out_q <= 1'b0;
        end else begin
            ref_div_out_q <= ref_div_out_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            diag_out_q <= 1'b0;
        end else begin
            diag_out_q <= diag_out_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_load_q <= 1'b0;
        end else begin
            cnt_load_q <= ctrl.cnt_load;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwr_down_q <= 1'b0;
        end else begin
            pwr_down_q <= ctrl.pwr_down;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pump_up_n = pump_up_n_q;
    assign pump_down_n = pump_down_n_q;
    assign integ_node = integ_node_q;
    assign lock_detect_o = lock_o_q;
    assign lock_detect_oe = lock_oe_q;
    assign main_div_out = main_div_out_q;
    assign ref_div_out = ref_div_out_q;
    assign diag_out = diag_out_q;
    assign cnt_load = cnt_load_q;
    assign pwr_down = pwr_down_q;

endmodule

// *** ped_pkg.sv ***
package ped_pkg;

    // APB register map (byte addresses)
    localparam logic [7:0] PED_ADDR_ENH = 8'h00;
    localparam logic [7:0] PED_ADDR_STATUS = 8'h04;
    localparam logic [7:0] PED_ADDR_EVENT = 8'h08;

    localparam int PED_ENH_W = 8;

    // Enhancement control fields
    localparam int PED_ENH_PWRDN_BIT = 3;
    localparam int PED_ENH_CNTLD_BIT = 4;
    localparam int PED_ENH_MODSEL_BIT = 5;
    localparam int PED_ENH_PRESC_BIT = 6;
    localparam int PED_ENH_DIVOFF_BIT = 7;
    localparam logic [7:0] PED_ENH_RESET = 8'h00;
    localparam logic [7:0] PED_ENH_USED_MASK = 8'hF8;

    // Status fields
    localparam int PED_ST_LOCK_BIT = 0;
    localparam int PED_ST_UP_BIT = 1;
    localparam int PED_ST_DOWN_BIT = 2;
    localparam int PED_ST_PWRDN_BIT = 3;
    localparam int PED_ST_CNTLD_BIT = 4;
    localparam int PED_ST_DIAG_BIT = 5;
    localparam int PED_ST_ENHACT_BIT = 6;

    // Sticky event fields, write one to clear
    localparam int PED_EV_UP_BIT = 0;
    localparam int PED_EV_DOWN_BIT = 1;
    localparam int PED_EV_W = 2;

    localparam logic [31:0] PED_ZERO_WORD = 32'h0000_0000;

    // Edge detector lanes
    localparam int PED_EDGE_N = 2;
    localparam int PED_LANE_MAIN = 0;
    localparam int PED_LANE_REF = 1;

    typedef enum logic [1:0] {
        PED_DIAG_LOW = 2'b00,
        PED_DIAG_MODSEL = 2'b01,
        PED_DIAG_PRESC = 2'b10
    } ped_diag_sel_t;

    typedef struct packed {
        logic div_off;
        logic presc_out;
        logic modsel_out;
        logic cnt_load;
        logic pwr_down;
    } ped_ctrl_t;

    typedef struct packed {
        logic up;
        logic down;
    } ped_pfd_t;

endpackage

// *** ped_rise_det.sv ***
`timescale 1ns/10ps
module ped_rise_det
    import ped_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [PED_EDGE_N-1:0] sig_in, // Sampled levels
    output logic [PED_EDGE_N-1:0] rise_q // One-cycle rise pulse
);
    logic [PED_EDGE_N-1:0] prev_q;

    genvar i;
    generate
        for (i = 0; i < PED_EDGE_N; i++) begin : g_lane
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    prev_q[i] <= 1'b0;
                    rise_q[i] <= 1'b0;
                end else begin
                    prev_q[i] <= sig_in[i];
                    rise_q[i] <= sig_in[i] & ~prev_q[i];
                end
            end
        end
    endgenerate
endmodule

// *** ped_chk.sv ***
`timescale 1ns/10ps
module ped_chk (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pready, // Ready
    input wire logic enh_en_n, // Enh enable
    input wire logic main_div_clk, // Main div
    input wire logic ref_div_clk, // Ref div
    input wire logic pump_up_n, // Up
    input wire logic pump_down_n, // Down
    input wire logic integ_node, // Node
    input wire logic lock_detect_o, // Lock level
    input wire logic lock_detect_oe, // Lock enable
    input wire logic main_div_out, // Main out
    input wire logic diag_out, // Diag
    input wire logic cnt_load, // Load
    input wire logic pwr_down // Power-down
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_RDY: assert property (psel && !penable |=> pready) else $error("ready late");
    AST_NAND: assert property (integ_node == !(pump_up_n && pump_down_n)) else $error("node bad");
    AST_LOCK: assert property (lock_detect_oe == !(pump_up_n && pump_down_n) && !lock_detect_o)
        else $error("lock bad");
    // Main must be quiet two samples, or a pending main edge would cancel the up pulse
    AST_UP: assert property ($rose(ref_div_clk) && $stable(main_div_clk) && $past(main_div_clk) ==
        $past(main_div_clk, 2) && pump_up_n && pump_down_n |-> ##2 (!pump_up_n || pwr_down)) else $error("no up");
    AST_DN: assert property ($rose(main_div_clk) && $stable(ref_div_clk) && $past(ref_div_clk) ==
        $past(ref_div_clk, 2) && pump_up_n && pump_down_n |-> ##2 (!pump_down_n || pwr_down)) else $error("no dn");
    AST_END: assert property ($rose(main_div_clk) && $stable(ref_div_clk) && !pump_up_n |-> ##2 pump_up_n)
        else $error("up long");
    AST_MAIN: assert property (main_div_out |-> $past(main_div_clk)) else $error("main out bad");
    AST_PWR: assert property (pwr_down && $past(pwr_down) |->
        pump_up_n && pump_down_n && !main_div_out && !diag_out) else $error("pwrdn leak");
    AST_GATE: assert property (cnt_load || diag_out |-> !$past(enh_en_n)) else $error("enh ungated");
endmodule

// *** ped_loop_model.sv ***
`timescale 1ns/10ps
module ped_loop_model (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic pump_up_n, // Up in
    input wire logic pump_down_n, // Down in
    output logic [15:0] tune_q // VCO tune level
);
    // Integrator only; no saturation, runs are short
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tune_q <= 16'h8000;
        end else if (!pump_up_n && pump_down_n) begin
            tune_q <= tune_q + 16'h0001;
        end else if (pump_up_n && !pump_down_n) begin
            tune_q <= tune_q - 16'h0001;
        end
    end
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import ped_pkg::*;
    logic clk_sys, rst, psel, penable, pwrite, enh_en_n, main_div_clk, ref_div_clk, modulus_select, presc_raw;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, pump_up_n, pump_down_n, integ_node, lock_detect_o, lock_detect_oe, er;
    logic main_div_out, ref_div_out, diag_out, cnt_load, pwr_down;
    logic [15:0] tune_q, t0;
    // Entry: data, en_n, modsel, presc, then diag, load, pwrdn, main out, ref out
    logic [15:0] tbl [10] = '{16'h2053, 16'h4033, 16'h6053, 16'h6023, 16'h0063, 16'h60E3, 16'h100B, 16'h8060,
        16'h98E3, 16'h2844};
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    ped_top i_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .enh_en_n, .main_div_clk, .ref_div_clk, .modulus_select, .presc_raw, .pump_up_n, .pump_down_n, .integ_node,
        .lock_detect_o, .lock_detect_oe, .main_div_out, .ref_div_out, .diag_out, .cnt_load, .pwr_down);
    ped_loop_model i_loop (.clk_sys, .rst, .pump_up_n, .pump_down_n, .tune_q);
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Waits for ready however long it takes; only the bench timeout ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Lead edge, then lag edge gap plus four cycles later; gap 0 makes them coincide
    task automatic phase(input logic lead_ref, input int gap, input logic [1:0] mid);
        @(posedge clk_sys);
        ref_div_clk <= lead_ref || gap == 0;
        main_div_clk <= !lead_ref || gap == 0;
        repeat (4) @(posedge clk_sys);
        chk("pump pins", {mid, ~&mid, ~&mid}, {pump_up_n, pump_down_n, integ_node, lock_detect_oe});
        repeat (gap) @(posedge clk_sys);
        ref_div_clk <= 1'b1;
        main_div_clk <= 1'b1;
        @(posedge clk_sys);
        chk("pump held", mid, {pump_up_n, pump_down_n});
        repeat (3) @(posedge clk_sys);
        chk("pumps idle", 4'hC, {pump_up_n, pump_down_n, integ_node, lock_detect_oe});
        ref_div_clk <= 1'b0;
        main_div_clk <= 1'b0;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        {psel, penable, pwrite, main_div_clk, ref_div_clk, modulus_select, presc_raw} = '0;
        paddr = 8'h00;
        pwdata = PED_ZERO_WORD;
        pstrb = 4'h1;
        enh_en_n = 1'b1;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        chk("reset pins", 5'h18, {pump_up_n, pump_down_n, integ_node, lock_detect_oe, lock_detect_o});
        apb(1'b0, PED_ADDR_ENH, PED_ZERO_WORD);
        chk("enh read", 32'h0000_0000, rd);
        apb(1'b0, 8'h0C, PED_ZERO_WORD);
        chk("unmapped err", 1'b1, er);
        t0 = tune_q;
        phase(1'b1, 6, 2'b01);
        chk("tune up", 1'b1, tune_q > t0);
        apb(1'b0, PED_ADDR_EVENT, PED_ZERO_WORD);
        chk("event up", 32'h0000_0001, rd);
        apb(1'b1, PED_ADDR_EVENT, 32'h0000_0003);
        t0 = tune_q;
        phase(1'b0, 5, 2'b10);
        chk("tune down", 1'b1, tune_q < t0);
        apb(1'b0, PED_ADDR_EVENT, PED_ZERO_WORD);
        chk("event down", 32'h0000_0002, rd);
        phase(1'b0, 0, 2'b11);
        @(posedge clk_sys);
        main_div_clk <= 1'b1;
        ref_div_clk <= 1'b1;
        foreach (tbl[i]) begin
            enh_en_n <= tbl[i][7];
            modulus_select <= tbl[i][6];
            presc_raw <= tbl[i][5];
            apb(1'b1, PED_ADDR_ENH, {24'h00_0000, tbl[i][15:8]});
            repeat (3) @(posedge clk_sys);
            chk("enh outs", tbl[i][4:0], {diag_out, cnt_load, pwr_down, main_div_out, ref_div_out});
        end
        main_div_clk <= 1'b0;
        ref_div_clk <= 1'b0;
        phase(1'b1, 4, 2'b11);
        apb(1'b0, PED_ADDR_STATUS, PED_ZERO_WORD);
        chk("status pwrdn", 1'b1, rd[PED_ST_PWRDN_BIT]);
        end_sim();
    end
endmodule
bind ped_top ped_chk i_chk (.clk_sys, .rst, .psel, .penable, .pready, .enh_en_n, .main_div_clk, .ref_div_clk,
    .pump_up_n, .pump_down_n, .integ_node, .lock_detect_o, .lock_detect_oe, .main_div_out, .diag_out, .cnt_load,
    .pwr_down);
